// ==== rtl/rsd_defs.vh ====
// Contract
// RQ1: in RS-422 mode the block is the only master and keeps its line driver on at all times.
// RQ2: four-wire RS-485 behaves as RS-422, the bus merely allowing several masters.
// RQ3: two-wire RS-485 sends only after seeing the shared pair idle, then enables its driver.
// RQ4: after the last character the driver stays on for a set number of quarter characters.
// RQ5: a hold time of zero quarter characters is refused as a configuration.
// RQ6: for point-to-point RS-485 the configuring party turns on Modbus with a repeat count of 3.
// RQ7: for point-to-multipoint RS-485 the configuring party sets a repeat count of at least 1.
// RQ8: there are no handshake lines; rates from 57.6 kbaud up need an error-detecting protocol.
// RQ9: the port baud rate may also be set to 300, 600 or 900 baud.
// RQ10: when the hold ends with nothing queued the driver turns off, a new character restarts it.
`ifndef RSD_DEFS_VH
`define RSD_DEFS_VH

`define RSD_CLK_HZ 25000000
`define RSD_OFF_CTRL 12'h000
`define RSD_OFF_STATUS 12'h004
`define RSD_OFF_HOLD 12'h008
`define RSD_OFF_BAUD 12'h00c
`define RSD_CTRL_MODE_LSB 0
`define RSD_CTRL_EN_BIT 2
`define RSD_CTRL_RST 3'h0
`define RSD_HOLD_RST 8'h04
`define RSD_BAUD_RST 4'h6
`define RSD_BAUD_MAX 4'hb
`define RSD_MODE_RS232 2'h0
`define RSD_MODE_RS422 2'h1
`define RSD_MODE_RS485_4W 2'h2
`define RSD_MODE_RS485_2W 2'h3
`define RSD_STAT_ERR_BIT 3
`define RSD_HALF_PER_QTR 3'h5
`define RSD_CHAR_BITS 4'ha
`define RSD_IDLE_QTRS 3'h4
`define RSD_BAUD_300 300
`define RSD_BAUD_600 600
`define RSD_BAUD_900 900
`define RSD_BAUD_1200 1200
`define RSD_BAUD_2400 2400
`define RSD_BAUD_4800 4800
`define RSD_BAUD_9600 9600
`define RSD_BAUD_19200 19200
`define RSD_BAUD_38400 38400
`define RSD_BAUD_57600 57600
`define RSD_BAUD_115200 115200
`define RSD_BAUD_230400 230400

`endif

// ==== rtl/rsd_sync.v ====
`default_nettype none

module rsd_sync (
	// clock and reset
	input wire clock,
	input wire resetn,
	// asynchronous level in, settled level out
	input wire din,
	output reg dout
);

	reg s1;
	reg s2;
	reg s3;

	// idle line is high
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			dout <= 1'b1;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end

endmodule // rsd_sync

`default_nettype wire

// ==== rtl/rsd_tick.v ====
`default_nettype none

module rsd_tick #(
	parameter CW = 18
) (
	// clock and reset
	input wire clock,
	input wire resetn,
	// control
	input wire run,
	input wire restart,
	input wire [CW-1:0] divisor,
	// one-cycle enable pulse
	output reg tick
);

	reg [CW-1:0] count;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count <= {CW{1'b0}};
			tick <= 1'b0;
		end else if (!run || restart) begin
			count <= {CW{1'b0}};
			tick <= 1'b0;
		end else if (count + {{(CW-1){1'b0}}, 1'b1} >= divisor) begin
			count <= {CW{1'b0}};
			tick <= 1'b1;
		end else begin
			count <= count + {{(CW-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end

endmodule // rsd_tick

`default_nettype wire

// ==== rtl/rsd_top.v ====
// Chosen here: register access over APB and the register offsets.
`include "rsd_defs.vh"
`default_nettype none

module rsd_top #(
	parameter DIV_W = 18
) (
	// clock and reset
	input wire clock,
	input wire resetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// character stream from the modem
	input wire tx_valid,
	input wire [7:0] tx_data,
	output wire tx_ready,
	// line transceiver
	input wire rxd_pin,
	output reg txd,
	output reg driver_en,
	output reg receiver_en_n
);

	localparam ST_IDLE = 2'h0;
	localparam ST_SEND = 2'h1;
	localparam ST_HOLD = 2'h2;

	// half-bit period in clocks for a baud index
	function [DIV_W-1:0] half_bit_cycles;
		input [3:0] idx;
		integer baud;
		integer cyc;
		begin
			baud = `RSD_BAUD_9600;
			case (idx)
				4'h0: baud = `RSD_BAUD_300; // RQ9
				4'h1: baud = `RSD_BAUD_600; // RQ9
				4'h2: baud = `RSD_BAUD_900; // RQ9
				4'h3: baud = `RSD_BAUD_1200;
				4'h4: baud = `RSD_BAUD_2400;
				4'h5: baud = `RSD_BAUD_4800;
				4'h6: baud = `RSD_BAUD_9600;
				4'h7: baud = `RSD_BAUD_19200;
				4'h8: baud = `RSD_BAUD_38400;
				4'h9: baud = `RSD_BAUD_57600;
				4'ha: baud = `RSD_BAUD_115200;
				4'hb: baud = `RSD_BAUD_230400;
				default: baud = `RSD_BAUD_9600;
			endcase
			cyc = (`RSD_CLK_HZ / 2) / baud;
			half_bit_cycles = cyc[DIV_W-1:0];
		end
	endfunction

	// register address match
	function is_reg;
		input [11:0] addr;
		input [11:0] off;
		begin
			is_reg = (addr == off);
		end
	endfunction

	reg [1:0] mode;
	reg enable;
	reg [7:0] hold_units;
	reg [3:0] baud_idx;
	reg cfg_err;
	reg [1:0] state;
	reg [9:0] shreg;
	reg [3:0] bit_cnt;
	reg half_phase;
	reg [2:0] half_cnt;
	reg [7:0] hold_cnt;
	reg [2:0] idle_qtrs;
	reg tick_restart;

	wire rx_level;
	wire half_tick;
	wire qtr_tick;
	wire two_wire;
	wire bus_idle;
	wire take_char;
	wire wr;
	wire rd_setup;
	wire mapped;
	wire bad_hold;
	wire bad_baud;
	wire [DIV_W-1:0] divisor;

	rsd_sync u_rx_sync (
		.clock(clock),
		.resetn(resetn),
		.din(rxd_pin),
		.dout(rx_level)
	);

	assign divisor = half_bit_cycles(baud_idx);

	rsd_tick #(
		.CW(DIV_W)
	) u_half_tick (
		.clock(clock),
		.resetn(resetn),
		.run(enable),
		.restart(tick_restart),
		.divisor(divisor),
		.tick(half_tick)
	);

	// apb decode, zero wait states
	assign mapped = is_reg(paddr, `RSD_OFF_CTRL) || is_reg(paddr, `RSD_OFF_STATUS)
		|| is_reg(paddr, `RSD_OFF_HOLD) || is_reg(paddr, `RSD_OFF_BAUD);
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign bad_hold = is_reg(paddr, `RSD_OFF_HOLD) && (pwdata[7:0] == 8'h00); // RQ5
	assign bad_baud = is_reg(paddr, `RSD_OFF_BAUD) && (pwdata[3:0] > `RSD_BAUD_MAX);
	assign pready = 1'b1;
	assign pslverr = psel && penable && (!mapped || (pwrite && (bad_hold || bad_baud)));

	// configuration registers
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			{enable, mode} <= `RSD_CTRL_RST;
			hold_units <= `RSD_HOLD_RST; // RQ4
			baud_idx <= `RSD_BAUD_RST;
		end else if (wr) begin
			if (is_reg(paddr, `RSD_OFF_CTRL)) begin
				mode <= pwdata[`RSD_CTRL_MODE_LSB +: 2];
				enable <= pwdata[`RSD_CTRL_EN_BIT];
			end
			if (is_reg(paddr, `RSD_OFF_HOLD) && !bad_hold) begin
				hold_units <= pwdata[7:0]; // RQ5
			end
			if (is_reg(paddr, `RSD_OFF_BAUD) && !bad_baud) begin
				baud_idx <= pwdata[3:0]; // RQ9
			end
		end
	end

	// refused write flag, set wins over clear
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cfg_err <= 1'b0;
		end else if (wr && (bad_hold || bad_baud)) begin
			cfg_err <= 1'b1; // RQ5
		end else if (wr && is_reg(paddr, `RSD_OFF_STATUS) && pwdata[`RSD_STAT_ERR_BIT]) begin
			cfg_err <= 1'b0;
		end
	end

	// read data captured in the setup cycle
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= 32'h00000000;
			if (is_reg(paddr, `RSD_OFF_CTRL)) begin
				prdata[`RSD_CTRL_MODE_LSB +: 2] <= mode;
				prdata[`RSD_CTRL_EN_BIT] <= enable;
			end
			if (is_reg(paddr, `RSD_OFF_STATUS)) begin
				prdata[0] <= driver_en;
				prdata[1] <= bus_idle;
				prdata[2] <= (state != ST_IDLE);
				prdata[`RSD_STAT_ERR_BIT] <= cfg_err;
				prdata[5:4] <= state;
			end
			if (is_reg(paddr, `RSD_OFF_HOLD)) begin
				prdata[7:0] <= hold_units;
			end
			if (is_reg(paddr, `RSD_OFF_BAUD)) begin
				prdata[3:0] <= baud_idx;
			end
		end
	end

	// quarter character from five half bits
	assign qtr_tick = half_tick && (half_cnt == `RSD_HALF_PER_QTR - 3'h1);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			half_cnt <= 3'h0;
		end else if (tick_restart || !enable) begin
			half_cnt <= 3'h0;
		end else if (qtr_tick) begin
			half_cnt <= 3'h0;
		end else if (half_tick) begin
			half_cnt <= half_cnt + 3'h1;
		end
	end

	// bus idle check for the shared pair
	assign two_wire = (mode == `RSD_MODE_RS485_2W);
	assign bus_idle = (idle_qtrs == `RSD_IDLE_QTRS);

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			idle_qtrs <= 3'h0;
		end else if (!enable || !rx_level) begin
			idle_qtrs <= 3'h0; // RQ3
		end else if (qtr_tick && !bus_idle) begin
			idle_qtrs <= idle_qtrs + 3'h1; // RQ3
		end
	end

	// character acceptance
	assign take_char = tx_valid && tx_ready;
	assign tx_ready = enable && ((state == ST_HOLD)
		|| ((state == ST_IDLE) && (!two_wire || bus_idle))); // RQ3 RQ10

	// send and hold sequencer
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= ST_IDLE;
			shreg <= 10'h3ff;
			bit_cnt <= 4'h0;
			half_phase <= 1'b0;
			hold_cnt <= 8'h00;
			tick_restart <= 1'b0;
		end else if (!enable) begin
			state <= ST_IDLE;
			shreg <= 10'h3ff;
			bit_cnt <= 4'h0;
			half_phase <= 1'b0;
			hold_cnt <= 8'h00;
			tick_restart <= 1'b0;
		end else begin
			tick_restart <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (take_char) begin
						shreg <= {1'b1, tx_data, 1'b0};
						bit_cnt <= 4'h0;
						half_phase <= 1'b0;
						tick_restart <= 1'b1;
						state <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (half_tick) begin
						half_phase <= !half_phase;
						if (half_phase) begin
							shreg <= {1'b1, shreg[9:1]};
							if (bit_cnt == `RSD_CHAR_BITS - 4'h1) begin
								hold_cnt <= 8'h00;
								tick_restart <= 1'b1;
								state <= ST_HOLD;
							end else begin
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
				end
				ST_HOLD: begin
					if (take_char) begin
						shreg <= {1'b1, tx_data, 1'b0}; // RQ10
						bit_cnt <= 4'h0;
						half_phase <= 1'b0;
						tick_restart <= 1'b1;
						state <= ST_SEND;
					end else if (qtr_tick) begin
						if (hold_cnt + 8'h01 >= hold_units) begin
							state <= ST_IDLE; // RQ4 RQ10
						end else begin
							hold_cnt <= hold_cnt + 8'h01; // RQ4
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// line outputs
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txd <= 1'b1;
			driver_en <= 1'b0;
			receiver_en_n <= 1'b0;
		end else begin
			txd <= (state == ST_SEND) ? shreg[0] : 1'b1;
			if (!enable) begin
				driver_en <= 1'b0;
				receiver_en_n <= 1'b0;
			end else if (two_wire) begin
				driver_en <= (state != ST_IDLE) || take_char; // RQ3 RQ10
				receiver_en_n <= (state != ST_IDLE) || take_char; // RQ10
			end else begin
				driver_en <= 1'b1; // RQ1 RQ2
				receiver_en_n <= 1'b0;
			end
		end
	end

endmodule // rsd_top

`default_nettype wire

// ==== testbench/rsd_top_chk.sv ====
`default_nettype none
module rsd_chk (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// stream and line
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rxd_pin,
	input wire logic txd,
	input wire logic driver_en,
	input wire logic receiver_en_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	sequence take_s;
		tx_valid && tx_ready;
	endsequence
	sequence start_s;
		(driver_en && !txd) [*8];
	endsequence
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access not answered");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	start_bit_a: assert property (take_s |=> driver_en ##1 start_s)
		else $error("no start bit after take");
	one_char_a: assert property (take_s |=> !tx_ready [*8])
		else $error("ready while sending");
	talk_cause_a: assert property ($rose(receiver_en_n) |-> $past(tx_valid && tx_ready))
		else $error("talk without character");
	listen_pair_a: assert property (receiver_en_n |-> driver_en)
		else $error("receiver off while silent");
	recv_return_a: assert property ($fell(receiver_en_n) |-> $fell(driver_en))
		else $error("receive not restored with release");
	read_hold_a: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved");
endmodule // rsd_chk
`default_nettype wire

// ==== testbench/rsd_bus_peer.sv ====
`default_nettype none
module rsd_bus_peer (
	// clock
	input wire logic clock,
	// other node talking
	input wire logic busy,
	output var logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] phase = 4'h0;
	initial rxd = 1'b1;
	// toggles every sixteen clocks while talking, fail-safe high when released
	always @(posedge clock) begin
		phase <= phase + 4'h1;
		if (!busy) begin
			rxd <= 1'b1;
		end else if (phase == 4'hf) begin
			rxd <= ~rxd;
		end
	end
endmodule // rsd_bus_peer
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HB = 54;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, tx_valid = 0, busy = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'd74504;
	logic [7:0] tx_data = 8'h00, got;
	logic err;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, tx_ready, rxd_pin, txd, driver_en, receiver_en_n;
	int mismatches = 0, tests_run = 0, cycles = 0, n, m_hold = 4, m_baud = 6;
	logic [7:0] sent[$];
	rsd_top dut (
		.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rxd_pin(rxd_pin), .txd(txd), .driver_en(driver_en), .receiver_en_n(receiver_en_n)
	);
	rsd_bus_peer peer (.clock(clock), .busy(busy), .rxd(rxd_pin));
	initial forever #20 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			mismatches++;
			finish_test();
		end
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task send(input logic [7:0] b);
		@(posedge clock);
		tx_valid <= 1;
		tx_data <= b;
		do @(posedge clock); while (tx_ready !== 1'b1);
		tx_valid <= 0;
		sent.push_back(b);
	endtask
	task rx_char(output logic [7:0] b);
		while (txd !== 1'b0) @(posedge clock);
		repeat (HB) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (2 * HB) @(posedge clock);
			b[i] = txd;
		end
		repeat (2 * HB) @(posedge clock);
		chk(txd, 1);
	endtask
	task finish_test();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clock);
		resetn <= 1;
		apb(12'h000, 0, 0);
		chk(rd, 0);
		apb(12'h008, 0, 0);
		chk(rd, m_hold);
		apb(12'h008, 1, 0);
		chk(err, 1);
		apb(12'h008, 0, 0);
		chk(rd, m_hold);
		apb(12'h004, 0, 0);
		chk(rd[3], 1);
		apb(12'h004, 1, 8);
		apb(12'h004, 0, 0);
		chk(rd[3], 0);
		apb(12'h010, 0, 0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(12'h00c, 1, 12);
		chk(err, 1);
		for (int i = 0; i < 12; i++) begin
			apb(12'h00c, 0, 0);
			chk(rd, m_baud);
			apb(12'h00c, 1, 32'(i));
			m_baud = i;
		end
		apb(12'h008, 1, 1);
		m_hold = 1;
		for (int m = 0; m < 3; m++) begin
			apb(12'h000, 1, 32'(4 + m));
			send(8'(rnd()));
			rx_char(got);
			chk(got, sent.pop_front());
			repeat (600) @(posedge clock);
			chk({driver_en, receiver_en_n}, 2'b10);
		end
		apb(12'h000, 1, 7);
		apb(12'h008, 1, 2);
		m_hold = 2;
		repeat (2000) @(posedge clock);
		chk({tx_ready, driver_en}, 0);
		busy <= 0;
		n = cycles;
		send(8'(rnd()));
		chk(cycles - n >= 3 * 5 * HB - 20 && cycles - n <= 4 * 5 * HB + 20, 1);
		rx_char(got);
		chk(got, sent.pop_front());
		send(8'(rnd()));
		rx_char(got);
		chk({got, driver_en}, {sent.pop_front(), 1'b1});
		n = 0;
		while (driver_en === 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk(n >= HB + m_hold * 5 * HB - 6 && n <= HB + m_hold * 5 * HB + 6, 1);
		chk(receiver_en_n, 0);
		finish_test();
	end
endmodule // tb
bind rsd_top rsd_chk chk (
	.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rxd_pin(rxd_pin),
	.txd(txd), .driver_en(driver_en), .receiver_en_n(receiver_en_n)
);
`default_nettype wire
